//--- nfh_ctrl.sv
`timescale 1ns/10ps
`include "nfh_consts.svh"

// write-data buffer; flags registered so the top sees flop outputs
module nfh_fifo #(parameter int W = 8, parameter int D = 32) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic [W-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [W-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic push, pop;

    // pointer and flag arithmetic
    always_comb begin
        push = in_valid_in && in_ready_out;
        pop = out_valid_out && out_ready_in;
        next_wp = push ? AW'(wp + 1'b1) : wp;
        next_rp = pop ? AW'(rp + 1'b1) : rp;
        next_cnt = (AW+1)'(cnt + push - pop);
    end

    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem[wp] <= in_data_in;
        end
        if (srst_in) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            in_ready_out <= 1'b0;
            out_valid_out <= 1'b0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
            in_ready_out <= next_cnt != (AW+1)'(D);
            out_valid_out <= next_cnt != '0;
        end
    end

    assign out_data_out = mem[rp];
endmodule // nfh_fifo

module nfh_ctrl #(
    parameter int PROG_CYC = `NFH_PROG_US * `NFH_CLK_MHZ,
    parameter int CBSY_CYC = `NFH_CBSY_US * `NFH_CLK_MHZ,
    parameter int BERS_CYC = `NFH_BERS_US * `NFH_CLK_MHZ,
    parameter int RST_CYC = `NFH_RST_US * `NFH_CLK_MHZ,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic cmd_valid_in,
    input wire nfh_pkg::nfh_cmd_s cmd_in,
    output logic cmd_ready_out,
    output logic res_valid_out,
    output nfh_pkg::nfh_res_s res_out,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic worn_out,
    output logic cle_out,
    output logic ale_out,
    output logic ce_n_out,
    output logic we_n_out,
    output logic read_strobe_n_out,
    output logic wp_n_out,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic io_oe_out,
    input wire logic busy_n_in
);
    localparam logic [19:0] WCYC = 20'(`NFH_WE_LOW + `NFH_WE_HIGH);
    localparam logic [19:0] RCYC = 20'(`NFH_RE_LOW + `NFH_RE_HIGH);
    localparam int ADL_CYC = `NFH_ADL_CYC;
    localparam logic [6:0] RETIRE_MAX = 7'(`NFH_BLOCKS - `NFH_VALID_MIN);

    nfh_pkg::nfh_st_e st, next_st;
    nfh_pkg::nfh_cmd_s cur, next_cur;
    logic [19:0] ph, next_ph;
    logic [11:0] idx, next_idx;
    logic [2:0] acnt, next_acnt;
    logic [17:0] last_row, next_last_row;
    logic [2:0] nop_main, nop_spare, next_nop_main, next_nop_spare;
    logic [6:0] retired, next_retired;
    logic next_cmd_ready, next_res_valid, next_rd_valid, next_cle, next_ale, next_ce_n;
    logic next_we_n, next_re_n, next_oe;
    logic [7:0] next_io, next_rd_data;
    nfh_pkg::nfh_res_s next_res;
    logic busy_meta, ready_s;
    logic [7:0] io_meta, io_s;
    logic f_valid, pop, wr_st, take, refuse, pe, spare;
    logic [7:0] f_data;

    nfh_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .in_data_in(wr_data_in),
        .in_valid_in(wr_valid_in),
        .in_ready_out(wr_ready_out),
        .out_data_out(f_data),
        .out_valid_out(f_valid),
        .out_ready_in(pop)
    );

    function automatic logic is_wr(input nfh_pkg::nfh_st_e s);
        return s == nfh_pkg::ST_CMD1 || s == nfh_pkg::ST_ADDR || s == nfh_pkg::ST_DIN ||
            s == nfh_pkg::ST_CMD2 || s == nfh_pkg::ST_STATC;
    endfunction

    // longest busy that the device may show for each operation
    function automatic logic [19:0] limit(input nfh_pkg::nfh_op_e op);
        case (op)
            nfh_pkg::OP_READ: return 20'(`NFH_TR_CYC);
            nfh_pkg::OP_PROG: return 20'(PROG_CYC);
            nfh_pkg::OP_CACHE: return 20'(CBSY_CYC);
            nfh_pkg::OP_ERASE: return 20'(BERS_CYC);
            default: return 20'(RST_CYC);
        endcase
    endfunction

    // byte placed on the bus for each write cycle; only defined codes exist here
    function automatic logic [7:0] out_byte(input nfh_pkg::nfh_st_e s,
            input nfh_pkg::nfh_cmd_s c, input logic [2:0] a, input logic [7:0] fd);
        logic [7:0] b;
        b = fd;
        if (s == nfh_pkg::ST_STATC) begin
            b = `NFH_CB_STATUS;
        end else if (s == nfh_pkg::ST_ADDR) begin
            case (a)
                3'h0: b = c.col[7:0];
                3'h1: b = {4'h0, c.col[11:8]};
                3'h2: b = c.row[7:0];
                3'h3: b = c.row[15:8];
                default: b = {6'h00, c.row[17:16]};
            endcase
        end else if (s == nfh_pkg::ST_CMD1) begin
            case (c.op)
                nfh_pkg::OP_READ: b = `NFH_CB_READ;
                nfh_pkg::OP_ERASE: b = `NFH_CB_ERASE;
                nfh_pkg::OP_RESET: b = `NFH_CB_RESET;
                nfh_pkg::OP_STATUS: b = `NFH_CB_STATUS;
                default: b = `NFH_CB_PROG;
            endcase
        end else if (s == nfh_pkg::ST_CMD2) begin
            case (c.op)
                nfh_pkg::OP_READ: b = `NFH_CB_READ2;
                nfh_pkg::OP_ERASE: b = `NFH_CB_ERASE2;
                nfh_pkg::OP_CACHE: b = `NFH_CB_CACHE2;
                default: b = `NFH_CB_PROG2;
            endcase
        end
        return b;
    endfunction

    // sequencer: one bus cycle is phase 0 setup, then strobe low, then strobe high
    always_comb begin
        next_st = st;
        next_cur = cur;
        next_ph = ph + 20'h00001;
        next_idx = idx;
        next_acnt = acnt;
        next_last_row = last_row;
        next_nop_main = nop_main;
        next_nop_spare = nop_spare;
        next_retired = retired;
        next_res_valid = 1'b0;
        next_res = res_out;
        next_rd_valid = 1'b0;
        next_rd_data = rd_data_out;
        next_io = io_out;
        pop = 1'b0;
        wr_st = is_wr(st);
        take = cmd_valid_in && cmd_ready_out;
        pe = cmd_in.op == nfh_pkg::OP_PROG || cmd_in.op == nfh_pkg::OP_CACHE ||
            cmd_in.op == nfh_pkg::OP_ERASE;
        spare = cmd_in.col >= 12'(`NFH_SPARE_COL);
        refuse = cmd_in.op > nfh_pkg::OP_STATUS
            || (pe && cmd_in.bad && cmd_in.row[17:`NFH_PAGE_BITS] != '0)
            || (pe && cmd_in.op != nfh_pkg::OP_ERASE && cmd_in.row == last_row
                && (spare ? nop_spare : nop_main) >= 3'(`NFH_NOP_MAX));
        case (st)
            nfh_pkg::ST_IDLE: begin
                next_ph = '0;
                if (take && refuse) begin
                    next_res_valid = 1'b1;
                    next_res = '{fail: 1'b0, timeout: 1'b0, refused: 1'b1};
                end else if (take) begin
                    next_cur = cmd_in;
                    next_idx = '0;
                    next_st = nfh_pkg::ST_CMD1;
                    // partial-program tally for the last programmed page only, cleared when its block is erased
                    if (cmd_in.op == nfh_pkg::OP_ERASE && cmd_in.row[17:`NFH_PAGE_BITS]
                            == last_row[17:`NFH_PAGE_BITS]) begin
                        next_nop_main = '0;
                        next_nop_spare = '0;
                    end else if (pe && cmd_in.op != nfh_pkg::OP_ERASE) begin
                        next_last_row = cmd_in.row;
                        if (cmd_in.row != last_row) begin
                            next_nop_main = 3'(!spare);
                            next_nop_spare = 3'(spare);
                        end else if (spare) begin
                            next_nop_spare = nop_spare + 3'h1;
                        end else begin
                            next_nop_main = nop_main + 3'h1;
                        end
                    end
                end
            end
            nfh_pkg::ST_CMD1: begin
                if (ph == WCYC) begin
                    next_ph = '0;
                    next_acnt = (cur.op == nfh_pkg::OP_ERASE) ? 3'h2 : 3'h0;
                    case (cur.op)
                        nfh_pkg::OP_RESET: next_st = nfh_pkg::ST_WB;
                        nfh_pkg::OP_STATUS: next_st = nfh_pkg::ST_RD;
                        default: next_st = nfh_pkg::ST_ADDR;
                    endcase
                end
            end
            nfh_pkg::ST_ADDR: begin
                if (ph == WCYC) begin
                    next_ph = '0;
                    next_acnt = acnt + 3'h1;
                    if (acnt == 3'h4) begin
                        next_st = (cur.op == nfh_pkg::OP_PROG || cur.op == nfh_pkg::OP_CACHE)
                            ? nfh_pkg::ST_ADL : nfh_pkg::ST_CMD2;
                    end
                end
            end
            nfh_pkg::ST_ADL: begin
                if (ph == 20'(ADL_CYC - 1)) begin
                    next_ph = '0;
                    next_st = nfh_pkg::ST_DIN;
                end
            end
            nfh_pkg::ST_DIN: begin
                // an empty buffer stalls before the strobe, never mid-cycle
                if (ph == '0 && !f_valid) begin
                    next_ph = '0;
                end else if (ph == WCYC) begin
                    next_ph = '0;
                    next_idx = idx + 12'h001;
                    if (idx == cur.len - 12'h001) begin
                        next_st = nfh_pkg::ST_CMD2;
                    end
                end
                pop = ph == '0 && f_valid;
            end
            nfh_pkg::ST_CMD2, nfh_pkg::ST_STATC: begin
                if (ph == WCYC) begin
                    next_ph = '0;
                    next_idx = '0;
                    next_st = (st == nfh_pkg::ST_CMD2) ? nfh_pkg::ST_WB : nfh_pkg::ST_RD;
                end
            end
            nfh_pkg::ST_WB: begin
                // device may take up to the write-to-busy time, plus our sync delay
                if (ph == 20'(`NFH_WB_CYC + 1)) begin
                    next_ph = '0;
                    next_st = nfh_pkg::ST_BUSY;
                end
            end
            nfh_pkg::ST_BUSY: begin
                next_ph = ph + 20'h00001;
                if (ready_s) begin
                    next_ph = '0;
                    case (cur.op)
                        nfh_pkg::OP_READ: next_st = nfh_pkg::ST_RD;
                        nfh_pkg::OP_RESET: begin
                            next_st = nfh_pkg::ST_IDLE;
                            next_res_valid = 1'b1;
                            next_res = '0;
                        end
                        // cache: ready here means the next page may be loaded already
                        default: next_st = nfh_pkg::ST_STATC;
                    endcase
                end else if (ph == limit(cur.op)) begin
                    next_st = nfh_pkg::ST_IDLE;
                    next_res_valid = 1'b1;
                    next_res = '{fail: 1'b1, timeout: 1'b1, refused: 1'b0};
                end
            end
            nfh_pkg::ST_RD: begin
                if (ph == 20'(`NFH_RE_LOW)) begin
                    next_rd_data = io_s;
                    next_rd_valid = cur.op == nfh_pkg::OP_READ;
                end
                if (ph == RCYC) begin
                    next_ph = '0;
                    next_idx = idx + 12'h001;
                    if (cur.op != nfh_pkg::OP_READ || idx == cur.len - 12'h001) begin
                        next_st = nfh_pkg::ST_IDLE;
                        next_res_valid = 1'b1;
                        next_res = '{fail: cur.op != nfh_pkg::OP_READ && cur.op !=
                            nfh_pkg::OP_STATUS && rd_data_out[0], timeout: 1'b0, refused: 1'b0};
                        // failed program or erase retires a block; worn past the margin
                        if (next_res.fail && retired != 7'h7F) begin
                            next_retired = retired + 7'h01;
                        end
                    end
                end
            end
            default: next_st = nfh_pkg::ST_IDLE;
        endcase
        if (wr_st && ph == '0 && next_ph != '0) begin
            next_io = out_byte(st, cur, acnt, f_data);
        end
        next_cmd_ready = next_st == nfh_pkg::ST_IDLE && !next_res_valid;
        next_cle = next_st == nfh_pkg::ST_CMD1 || next_st == nfh_pkg::ST_CMD2 ||
            next_st == nfh_pkg::ST_STATC;
        next_ale = next_st == nfh_pkg::ST_ADDR;
        next_ce_n = next_st == nfh_pkg::ST_IDLE;
        next_oe = is_wr(next_st);
        next_we_n = !(is_wr(next_st) && next_ph != '0 && next_ph <= 20'(`NFH_WE_LOW));
        next_re_n = !(next_st == nfh_pkg::ST_RD && next_ph != '0 &&
            next_ph <= 20'(`NFH_RE_LOW));
    end

    // registers; pins and the busy line pass two flops before the sequencer reads them
    always_ff @(posedge mclk_in) begin
        busy_meta <= busy_n_in;
        ready_s <= busy_meta;
        io_meta <= io_in;
        io_s <= io_meta;
        if (srst_in) begin
            st <= nfh_pkg::ST_IDLE;
            cur <= '0;
            ph <= '0;
            idx <= '0;
            acnt <= '0;
            last_row <= '1;
            nop_main <= '0;
            nop_spare <= '0;
            retired <= '0;
            cmd_ready_out <= 1'b0;
            res_valid_out <= 1'b0;
            res_out <= '0;
            rd_valid_out <= 1'b0;
            rd_data_out <= '0;
            worn_out <= 1'b0;
            cle_out <= 1'b0;
            ale_out <= 1'b0;
            ce_n_out <= 1'b1;
            we_n_out <= 1'b1;
            read_strobe_n_out <= 1'b1;
            wp_n_out <= 1'b0; // protected until out of reset
            io_out <= '0;
            io_oe_out <= 1'b0;
        end else begin
            st <= next_st;
            cur <= next_cur;
            ph <= next_ph;
            idx <= next_idx;
            acnt <= next_acnt;
            last_row <= next_last_row;
            nop_main <= next_nop_main;
            nop_spare <= next_nop_spare;
            retired <= next_retired;
            cmd_ready_out <= next_cmd_ready;
            res_valid_out <= next_res_valid;
            res_out <= next_res;
            rd_valid_out <= next_rd_valid;
            rd_data_out <= next_rd_data;
            worn_out <= next_retired > RETIRE_MAX;
            cle_out <= next_cle;
            ale_out <= next_ale;
            ce_n_out <= next_ce_n;
            we_n_out <= next_we_n;
            read_strobe_n_out <= next_re_n;
            wp_n_out <= 1'b1;
            io_out <= next_io;
            io_oe_out <= next_oe;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    sequence s_last_addr;
        st == nfh_pkg::ST_ADDR && acnt == 3'h4 ##1 st == nfh_pkg::ST_ADL;
    endsequence
    property p_adl; s_last_addr |-> ##ADL_CYC st == nfh_pkg::ST_DIN && we_n_out; endproperty
    a_adl: assert property (p_adl) else $error("address to data gap too short");
    property p_read_bound;
        st == nfh_pkg::ST_BUSY && cur.op == nfh_pkg::OP_READ |-> ph <= 20'(`NFH_TR_CYC);
    endproperty
    a_read_bound: assert property (p_read_bound) else $error("read wait overrun");
    property p_cache_bound;
        st == nfh_pkg::ST_BUSY && cur.op == nfh_pkg::OP_CACHE |-> ph <= 20'(CBSY_CYC);
    endproperty
    a_cache_bound: assert property (p_cache_bound) else $error("cache busy overrun");
    property p_rst_bound;
        st == nfh_pkg::ST_BUSY && cur.op == nfh_pkg::OP_RESET |-> ph <= 20'(RST_CYC);
    endproperty
    a_rst_bound: assert property (p_rst_bound) else $error("reset wait overrun");
    property p_pe_timeout;
        st == nfh_pkg::ST_BUSY && !ready_s && ph == limit(cur.op) |=>
            res_valid_out && res_out.timeout && st == nfh_pkg::ST_IDLE;
    endproperty
    a_pe_timeout: assert property (p_pe_timeout) else $error("timeout not reported");
    property p_nop; nop_main <= 3'(`NFH_NOP_MAX) && nop_spare <= 3'(`NFH_NOP_MAX); endproperty
    a_nop: assert property (p_nop) else $error("partial program count exceeded");
    property p_bad;
        take && pe && cmd_in.bad && cmd_in.row[17:`NFH_PAGE_BITS] != '0 |=>
            res_valid_out && res_out.refused && st == nfh_pkg::ST_IDLE;
    endproperty
    a_bad: assert property (p_bad) else $error("bad block not refused");
    property p_blk0;
        take && cmd_in.op == nfh_pkg::OP_ERASE && cmd_in.row[17:`NFH_PAGE_BITS] == '0 |=>
            st == nfh_pkg::ST_CMD1;
    endproperty
    a_blk0: assert property (p_blk0) else $error("block zero refused");
    property p_cmd_code;
        cle_out && !we_n_out |-> io_out inside {`NFH_CB_READ, `NFH_CB_READ2, `NFH_CB_PROG,
            `NFH_CB_PROG2, `NFH_CB_CACHE2, `NFH_CB_ERASE, `NFH_CB_ERASE2, `NFH_CB_RESET,
            `NFH_CB_STATUS};
    endproperty
    a_cmd_code: assert property (p_cmd_code) else $error("undefined command code");
    property p_quiet_busy; st == nfh_pkg::ST_BUSY |-> we_n_out && read_strobe_n_out; endproperty
    a_quiet_busy: assert property (p_quiet_busy) else $error("strobe while busy");
endmodule // nfh_ctrl

//--- nfh_consts.svh
// What this block does
// - no page is programmed more than 4 partial times with no other page programmed between, main and spare areas counted apart.
// - at least 100 ns separate the last address write edge from the first data write edge.
// - program and erase are never sent to a block marked bad at the factory, except block 0.
// - the host copes with as few as 4016 good blocks of 4096 over the device life.
// - only command codes of the defined set are ever sent.
`ifndef NFH_CONSTS_SVH
`define NFH_CONSTS_SVH
`define NFH_CLK_MHZ 125
`define NFH_WE_LOW 4
`define NFH_WE_HIGH 8
`define NFH_RE_LOW 6
`define NFH_RE_HIGH 4
`define NFH_TR_US 25
`define NFH_PROG_US 700
`define NFH_CBSY_US 700
`define NFH_BERS_US 3000
`define NFH_RST_US 500
`define NFH_ADL_NS 100
`define NFH_WB_NS 100
`define NFH_TR_CYC (`NFH_TR_US * `NFH_CLK_MHZ)
`define NFH_ADL_CYC ((`NFH_ADL_NS * `NFH_CLK_MHZ + 999) / 1000)
`define NFH_WB_CYC ((`NFH_WB_NS * `NFH_CLK_MHZ + 999) / 1000)
`define NFH_NOP_MAX 4
`define NFH_SPARE_COL 2048
`define NFH_BLOCKS 4096
`define NFH_VALID_MIN 4016
`define NFH_PAGE_BITS 6
`define NFH_CB_READ 8'h00
`define NFH_CB_READ2 8'h30
`define NFH_CB_PROG 8'h80
`define NFH_CB_PROG2 8'h10
`define NFH_CB_CACHE2 8'h15
`define NFH_CB_ERASE 8'h60
`define NFH_CB_ERASE2 8'hD0
`define NFH_CB_RESET 8'hFF
`define NFH_CB_STATUS 8'h70
`endif

//--- nfh_pkg.sv
package nfh_pkg;
    typedef enum logic [2:0] {
        OP_READ = 3'b000,
        OP_PROG = 3'b001,
        OP_CACHE = 3'b010,
        OP_ERASE = 3'b011,
        OP_RESET = 3'b100,
        OP_STATUS = 3'b101
    } nfh_op_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CMD1 = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_ADL = 4'b0011,
        ST_DIN = 4'b0100,
        ST_CMD2 = 4'b0101,
        ST_WB = 4'b0110,
        ST_BUSY = 4'b0111,
        ST_STATC = 4'b1000,
        ST_RD = 4'b1001
    } nfh_st_e;

    typedef struct packed {
        nfh_op_e op;
        logic [17:0] row;
        logic [11:0] col;
        logic [11:0] len;
        logic bad;
    } nfh_cmd_s;

    typedef struct packed {
        logic fail;
        logic timeout;
        logic refused;
    } nfh_res_s;
endpackage

//--- nfh_dev_model.sv
`timescale 1ns/10ps
// flash device model: latches on write strobe rise, busy timed in ns
module nfh_dev_model #(parameter int BUSY_NS = 400) (
    input wire logic cle_in,
    input wire logic ale_in,
    input wire logic ce_n_in,
    input wire logic we_n_in,
    input wire logic read_strobe_n_in,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic busy_n_out,
    input wire logic fail_in,
    input wire logic slow_in
);
    logic [7:0] ptr = 8'h00;
    logic st = 1'b0;
    int left = 0, nadr = 0, ops = 0, viol = 0, bad_cmd = 0, adl_bad = 0;
    realtime t_adr = 0;
    logic [7:0] din_q[$];
    initial io_out = 8'h00;
    // busy countdown; a reset command simply reloads it
    always #1 if (left > 0) left--;
    assign busy_n_out = (left == 0);
    // commands, addresses and data latch on the write strobe rise
    always @(posedge we_n_in) if (!ce_n_in) begin
        if (cle_in) begin
            nadr = 0;
            if (left > 0 && io_in != 8'hFF && io_in != 8'h70) viol++;
            case (io_in)
                8'h00: st = 1'b0;
                8'h30: left = 3000;
                8'h80: din_q.delete();
                8'h10, 8'hD0: begin
                    ops++;
                    left = slow_in ? 4000 : BUSY_NS;
                end
                8'h15: begin
                    ops++;
                    left = BUSY_NS / 4;
                end
                8'h60: ;
                8'hFF: left = 300;
                8'h70: st = 1'b1;
                default: bad_cmd++;
            endcase
        end else if (ale_in) begin
            if (nadr == 0) ptr = io_in;
            nadr++;
            t_adr = $realtime;
        end else begin
            if (din_q.size() == 0 && $realtime - t_adr < 100) adl_bad++;
            din_q.push_back(io_in);
        end
    end
    // byte appears after access time; the bus shows its inverse once hold ends
    always @(negedge read_strobe_n_in) if (!ce_n_in) begin
        #10 io_out = st ? {7'h60, fail_in} : ptr;
        if (!st) ptr++;
    end
    always @(posedge read_strobe_n_in) #15 io_out = ~io_out;
endmodule // nfh_dev_model

//--- nfh_tb.sv
`timescale 1ns/10ps
module testbench;
    logic mclk_in = 0, srst_in = 1, cmd_valid_in = 0, wr_valid_in = 0, fail = 0, slow = 0;
    logic [7:0] wr_data_in = 8'h00, rd_data_out, io_in, io_out, dev_io;
    nfh_pkg::nfh_cmd_s cmd_in = '0;
    nfh_pkg::nfh_res_s res_out;
    logic cmd_ready_out, res_valid_out, wr_ready_out, rd_valid_out, worn_out, cle_out;
    logic ale_out, ce_n_out, we_n_out, read_strobe_n_out, wp_n_out, io_oe_out, busy_n_in;
    logic [7:0] eb[$], pd[$];
    logic [2:0] er[$];
    logic [17:0] r;
    int failures = 0, cmp_count = 0, k;
    always #4 mclk_in = ~mclk_in;
    // shared bus: controller level while it drives, else the device's
    assign io_in = io_oe_out ? io_out : dev_io;
    nfh_ctrl #(.PROG_CYC(200), .CBSY_CYC(200), .BERS_CYC(200), .RST_CYC(200)) u_nfh_ctrl (.*);
    nfh_dev_model u_nfh_dev_model (.cle_in(cle_out), .ale_in(ale_out), .ce_n_in(ce_n_out),
        .we_n_in(we_n_out), .read_strobe_n_in(read_strobe_n_out), .io_in(io_in),
        .io_out(dev_io), .busy_n_out(busy_n_in), .fail_in(fail), .slow_in(slow));
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report;
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // keep valid up; ready is a flop, so the level seen here is what the next edge samples
    task automatic push(input int n);
        pd.delete();
        wr_valid_in = 1;
        repeat (n) begin
            wr_data_in = 8'($urandom);
            if (wr_ready_out === 1'b1) pd.push_back(wr_data_in);
            @(negedge mclk_in);
        end
        wr_valid_in = 0;
    endtask
    // note expectations, hold the request until taken, wait for the result
    task automatic op(input logic [2:0] o, input logic [17:0] rw, input logic [11:0] c,
            input logic [11:0] n, input logic b, input logic [2:0] e);
        int i;
        for (i = 0; o == 3'd0 && i < n; i++) eb.push_back(c[7:0] + 8'(i));
        er.push_back(e);
        cmd_in = {o, rw, c, n, b};
        cmd_valid_in = 1;
        while (cmd_ready_out !== 1'b1) @(negedge mclk_in);
        @(negedge mclk_in);
        cmd_valid_in = 0;
        for (i = 0; res_valid_out !== 1'b1 && i < 9000; i++) @(negedge mclk_in);
        if (i == 9000) failures++; // result never came
        @(negedge mclk_in);
    endtask
    // results are pulses, looked at mid-cycle where the flops have settled
    always @(negedge mclk_in) begin
        if (rd_valid_out === 1'b1) chk("rd_data", eb.pop_front(), rd_data_out);
        if (res_valid_out === 1'b1) chk("result", er.pop_front(), res_out);
    end
    initial begin
        void'($urandom(32'hEB93C97C));
        repeat (6) @(negedge mclk_in);
        srst_in = 0;
        repeat (2) @(negedge mclk_in);
        r = {12'($urandom_range(4000, 1)), 6'($urandom)};
        op(0, r, {1'b0, 11'($urandom)}, 5, 0, 0);
        push(40);
        chk("fifo_fill", 32, 12'(pd.size()));
        op(1, r, 0, 32, 0, 0);
        foreach (pd[i]) chk("prog_data", pd[i], u_nfh_dev_model.din_q[i]);
        repeat (3) begin
            push(1);
            op(1, r, 12'h010, 1, 0, 0);
        end
        op(1, r, 12'h020, 1, 0, 3'b001);
        push(1);
        op(1, r, 12'h800, 1, 0, 0);
        push(2);
        op(2, r + 18'd64, 0, 2, 0, 0);
        k = u_nfh_dev_model.ops;
        op(3, r, 0, 0, 1, 3'b001);
        chk("array_ops", 12'(k), 12'(u_nfh_dev_model.ops));
        push(1);
        op(1, 18'd1, 0, 1, 1, 0);
        op(3, 18'd0, 0, 0, 1, 0);
        fail = 1;
        op(3, r, 0, 0, 0, 3'b100);
        fail = 0;
        slow = 1;
        push(1);
        op(1, r + 18'd128, 0, 1, 0, 3'b110);
        slow = 0;
        op(4, 0, 0, 0, 0, 0);
        for (k = 6; k < 8; k++) op(3'(k), r, 0, 0, 0, 3'b001);
        op(5, r, 0, 0, 0, 0);
        chk("worn", 0, 12'(worn_out));
        chk("wp_n", 1, 12'(wp_n_out));
        chk("busy_viol", 0, 12'(u_nfh_dev_model.viol));
        chk("bad_cmd", 0, 12'(u_nfh_dev_model.bad_cmd));
        chk("adl_short", 0, 12'(u_nfh_dev_model.adl_bad));
        final_report();
    end
    // hang guard, well beyond the few thousand cycles the run needs
    initial begin
        #400000;
        failures++;
        final_report();
    end
endmodule // testbench
